// >>> core/bus_interrupter.sv
// Purpose: Four-source bus interrupter with vector response and acknowledge daisy chain
// Assumes: All bus and source pins are asynchronous and pass two flops
// Notes: Open-collector request outputs are modelled as output plus active-low enable
// Behaviour
// R1: Four active-low local request inputs accepted
// R2: Drive matching level request low, else float
// R3: Drive data bus only when supplying data
// R4: Address selects one of eight registers
// R5: Chip select qualifies register access
// R6: Outside logic builds chip select from strobes
// R7: Read high, write low on direction line
// R8: Acknowledge after data driven or captured
// R9: Acknowledge-cycle input qualified by strobes outside
// R10: Compare acknowledged level with requested levels
// R11: Chain in: answer on match, else pass
// R12: Wait chain in; withhold chain out answering
// R13: Index strobe and source number during acknowledge
// R14: Four vector bytes, driven when source acknowledged
// R15: Four read/write 8-bit control registers
// R16: Low three bits pick level, zero disables
// R17: Enable bit four gates the request
// R18: Auto-clear bit three drops enable on acknowledge
// R19: Bit five set: no vector, no acknowledge
// R20: Lowest-numbered matching source wins
`timescale 1ns/10ps
module bus_interrupter (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [bus_irq_pkg::NUM_SRC-1:0] local_source_request_n_i,
    input wire bus_irq_pkg::bus_req_t bus_i,
    output bus_irq_pkg::bus_rsp_t bus_o,
    output logic [bus_irq_pkg::NUM_LVL:1] irq_n_o,
    output logic [bus_irq_pkg::NUM_LVL:1] irq_oe_n_o,
    output logic ack_index_valid_n_o,
    output logic ack_source_index_bit0_o,
    output logic ack_source_index_bit1_o
);
    import bus_irq_pkg::*;

    typedef enum {ST_IDLE, ST_DRIVE, ST_ACK, ST_PASS, ST_EXT} state_t;

    localparam int SYNC_W = NUM_SRC + $bits(bus_req_t);
    localparam logic [SYNC_W-1:0] SYNC_RST = {{NUM_SRC{1'b1}}, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};

    // ****************************************
    // Input synchronisation
    // ****************************************
    logic [NUM_SRC-1:0] src_n;
    bus_req_t req;
    sync2 #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .d_i({local_source_request_n_i, bus_i}), // R1
        .q_o({src_n, req})
    );

    function automatic logic [LVL_W-1:0] lvl_of(input logic [7:0] c);
        lvl_of = c[CTL_LVL_LSB +: LVL_W];
    endfunction

    // ****************************************
    // Registers and cycle state
    // ****************************************
    logic [7:0] ctl_ff [NUM_SRC];
    logic [7:0] nxt_ctl [NUM_SRC];
    logic [7:0] vec_ff [NUM_SRC];
    logic [7:0] nxt_vec [NUM_SRC];
    state_t state_ff, nxt_state;
    logic [7:0] rdata_ff, nxt_rdata;
    logic [1:0] idx_ff, nxt_idx;
    logic [NUM_SRC-1:0] active;
    logic [NUM_LVL:1] irq_lvl;
    logic hit;
    logic [1:0] hit_idx;

    // Active sources and the request lines they drive
    always_comb begin
        irq_lvl = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            active[i] = !src_n[i] && ctl_ff[i][CTL_ENABLE_BIT] && lvl_of(ctl_ff[i]) != 3'h0; // R16 R17
            if (active[i]) begin
                irq_lvl[lvl_of(ctl_ff[i])] = 1'b1; // R2
            end
        end
    end

    // Highest priority goes to the lowest index so one answer per cycle
    always_comb begin
        hit = 1'b0;
        hit_idx = 2'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (active[i] && lvl_of(ctl_ff[i]) == req.addr) begin // R10
                hit = 1'b1; // R20
                hit_idx = i[1:0];
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_rdata = rdata_ff;
        nxt_idx = idx_ff;
        for (int i = 0; i < NUM_SRC; i++) begin
            nxt_ctl[i] = ctl_ff[i];
            nxt_vec[i] = vec_ff[i];
        end
        unique case (state_ff)
            ST_IDLE: begin
                if (!req.sel_n && !req.ack_cycle_n) begin
                    nxt_state = ST_IDLE;
                end else if (!req.sel_n) begin // R5
                    if (req.read) begin // R7
                        nxt_rdata = req.addr[2] ? vec_ff[req.addr[1:0]] : ctl_ff[req.addr[1:0]]; // R4
                        nxt_state = ST_DRIVE;
                    end else begin
                        if (req.addr[2]) begin
                            nxt_vec[req.addr[1:0]] = req.wdata; // R4
                        end else begin
                            nxt_ctl[req.addr[1:0]] = req.wdata; // R15
                        end
                        nxt_state = ST_ACK; // R8
                    end
                end else if (!req.ack_cycle_n && !req.chain_in_n) begin // R12
                    if (hit) begin // R11
                        nxt_idx = hit_idx;
                        nxt_rdata = vec_ff[hit_idx]; // R14
                        if (ctl_ff[hit_idx][CTL_AUTOCLR_BIT]) begin
                            nxt_ctl[hit_idx][CTL_ENABLE_BIT] = 1'b0; // R18
                        end
                        if (ctl_ff[hit_idx][CTL_FLAGCLR_BIT]) begin
                            nxt_ctl[hit_idx][CTL_FLAG_BIT] = 1'b0;
                        end
                        nxt_state = ctl_ff[hit_idx][CTL_EXT_BIT] ? ST_EXT : ST_DRIVE; // R19
                    end else begin
                        nxt_state = ST_PASS; // R11
                    end
                end
            end
            ST_DRIVE: begin
                nxt_state = ST_ACK; // R8
            end
            ST_ACK, ST_PASS, ST_EXT: begin
                if (req.sel_n && req.ack_cycle_n) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            rdata_ff <= 8'h00;
            idx_ff <= 2'h0;
            for (int i = 0; i < NUM_SRC; i++) begin
                ctl_ff[i] <= CTL_RST;
                vec_ff[i] <= VEC_RST;
            end
        end else begin
            state_ff <= nxt_state;
            rdata_ff <= nxt_rdata;
            idx_ff <= nxt_idx;
            for (int i = 0; i < NUM_SRC; i++) begin
                ctl_ff[i] <= nxt_ctl[i];
                vec_ff[i] <= nxt_vec[i];
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic iack_phase;
    logic driving;
    logic ack_oe_n;
    assign iack_phase = !req.ack_cycle_n && (state_ff == ST_DRIVE || state_ff == ST_ACK);
    assign driving = (state_ff == ST_DRIVE || state_ff == ST_ACK) && req.read;
    // Acknowledge is open drain: sunk only in the acknowledge state, so the
    // wired value seen outside is the enable itself
    assign ack_oe_n = !(state_ff == ST_ACK); // R8
    // One assignment for the whole carrier keeps a single driver on the port
    assign bus_o = '{rdata: rdata_ff, data_oe_n: !driving, xfer_ack_n: ack_oe_n,
        chain_out_n: !(state_ff == ST_PASS)}; // R3 R8 R11 R12
    assign irq_n_o = '0;
    assign irq_oe_n_o = ~irq_lvl; // R2
    assign ack_index_valid_n_o = !(iack_phase || state_ff == ST_EXT); // R13
    assign ack_source_index_bit0_o = idx_ff[0]; // R13
    assign ack_source_index_bit1_o = idx_ff[1]; // R13

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_read_taken;
        state_ff == ST_IDLE && !req.sel_n && req.ack_cycle_n && req.read;
    endsequence

    read_data_ack_a: assert property (s_read_taken |=> !bus_o.data_oe_n ##1 !ack_oe_n) // R8
        else $error("read not driven before acknowledge");
    write_store_a: assert property (state_ff == ST_IDLE && !req.sel_n && req.ack_cycle_n && !req.read
        && !req.addr[2] |=> ctl_ff[$past(req.addr[1:0])] == $past(req.wdata)) // R15
        else $error("control write lost");
    irq_gate_a: assert property (!ctl_ff[0][CTL_ENABLE_BIT] && !ctl_ff[1][CTL_ENABLE_BIT]
        && !ctl_ff[2][CTL_ENABLE_BIT] && !ctl_ff[3][CTL_ENABLE_BIT] |-> &irq_oe_n_o) // R17
        else $error("request without enable");
    chain_pass_a: assert property (state_ff == ST_IDLE && req.sel_n && !req.ack_cycle_n
        && !req.chain_in_n && !hit |=> !bus_o.chain_out_n) // R11
        else $error("chain not passed");
    chain_hold_a: assert property (state_ff == ST_IDLE && req.chain_in_n |=> bus_o.chain_out_n) // R12
        else $error("chain passed without chain in");
    ext_quiet_a: assert property (state_ff == ST_EXT |-> bus_o.data_oe_n && ack_oe_n
        && !ack_index_valid_n_o) // R19
        else $error("external response drove bus");
    auto_clear_a: assert property (state_ff == ST_IDLE && req.sel_n && !req.ack_cycle_n
        && !req.chain_in_n && hit && ctl_ff[hit_idx][CTL_AUTOCLR_BIT]
        |=> !ctl_ff[$past(hit_idx)][CTL_ENABLE_BIT]) // R18
        else $error("auto-clear missed");
    prio_low_a: assert property (state_ff == ST_IDLE && req.sel_n && !req.ack_cycle_n
        && !req.chain_in_n && hit && active[0] && lvl_of(ctl_ff[0]) == req.addr
        |=> idx_ff == 2'h0) // R20
        else $error("wrong source chosen");
    vec_out_a: assert property (state_ff == ST_DRIVE && !req.ack_cycle_n
        |-> bus_o.rdata == vec_ff[idx_ff]) // R14
        else $error("wrong vector");
endmodule

// >>> core/bus_irq_pkg.sv
// Purpose: Shared constants and carrier types for the four-source bus interrupter
// Assumes: 8-bit data bus, three address inputs, seven request levels
// Notes: Control byte layout is flag, flag auto-clear, external, enable, auto-clear, level
package bus_irq_pkg;
    localparam int NUM_SRC = 4;
    localparam int DATA_W = 8;
    localparam int LVL_W = 3;
    localparam int NUM_LVL = 7;
    // ****************************************
    // Control register field positions
    // ****************************************
    localparam int CTL_LVL_LSB = 0;
    localparam int CTL_AUTOCLR_BIT = 3;
    localparam int CTL_ENABLE_BIT = 4;
    localparam int CTL_EXT_BIT = 5;
    localparam int CTL_FLAGCLR_BIT = 6;
    localparam int CTL_FLAG_BIT = 7;
    // ****************************************
    // Register addresses and reset values
    // ****************************************
    localparam logic [2:0] ADDR_CTL0 = 3'h0;
    localparam logic [2:0] ADDR_CTL1 = 3'h1;
    localparam logic [2:0] ADDR_CTL2 = 3'h2;
    localparam logic [2:0] ADDR_CTL3 = 3'h3;
    localparam logic [2:0] ADDR_VEC0 = 3'h4;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] VEC_RST = 8'h0f;

    typedef struct packed {
        logic [2:0] addr;
        logic read;
        logic sel_n;
        logic ack_cycle_n;
        logic chain_in_n;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic data_oe_n;
        logic xfer_ack_n;
        logic chain_out_n;
    } bus_rsp_t;
endpackage

// >>> core/sync2.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous inputs
// Assumes: Each bit is an independent level
// Notes: Reset value is a parameter so active-low pins idle high
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule

// >>> dv/bus_far_side_model.sv
// Purpose: Far-side wiring of the system bus seen by the interrupter
// Assumes: Request lines carry pull-ups, the data bus has none
// Notes: A released data bus shows the inverse of its last value
`timescale 1ns/10ps
module bus_far_side_model (
    input wire logic core_clk_i,
    input wire bus_irq_pkg::bus_rsp_t bus_rsp_i,
    input wire logic [bus_irq_pkg::NUM_LVL:1] irq_n_i,
    input wire logic [bus_irq_pkg::NUM_LVL:1] irq_oe_n_i,
    output logic [bus_irq_pkg::NUM_LVL:1] irq_line_o,
    output logic [7:0] data_line_o
);
    import bus_irq_pkg::*;
    logic [7:0] last_ff;
    // Pull-up holds each line high unless the device sinks it
    assign irq_line_o = irq_oe_n_i | irq_n_i;
    // Stale data must never pass for a valid byte
    assign data_line_o = bus_rsp_i.data_oe_n ? ~last_ff : bus_rsp_i.rdata;
    always_ff @(posedge core_clk_i) begin
        last_ff <= data_line_o;
    end
endmodule

// >>> dv/bus_interrupter_tb_top.sv
// Purpose: Self-checking bench for the four-source bus interrupter
// Assumes: Register accesses are held until the transfer acknowledge is seen
// Notes: Inputs change on the falling edge, the design samples on the rising one
`timescale 1ns/10ps
module bus_interrupter_tb_top;
    import bus_irq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] src_n = 4'hf;
    bus_req_t req = '{3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
    bus_rsp_t rsp;
    logic [7:1] irq_n, irq_oe_n, irq_line;
    logic [7:0] data_line, d, ctl_m [4], vec_m [4], got_d;
    logic idx_v_n, idx0, idx1, got_oe, got_v, got_co, got_a;
    logic [1:0] got_i;
    int failures = 0;
    int total_checks = 0;
    int seed = 32'h81c16faa;
    int lvl;
    always #50 clk = ~clk;
    bus_interrupter dut (.core_clk_i(clk), .rst_n_i(rst_n), .local_source_request_n_i(src_n),
        .bus_i(req), .bus_o(rsp), .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n),
        .ack_index_valid_n_o(idx_v_n), .ack_source_index_bit0_o(idx0),
        .ack_source_index_bit1_o(idx1));
    bus_far_side_model far (.core_clk_i(clk), .bus_rsp_i(rsp), .irq_n_i(irq_n),
        .irq_oe_n_i(irq_oe_n), .irq_line_o(irq_line), .data_line_o(data_line));
    // ****************************************
    // Helpers
    // ****************************************
    task check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [7:1] exp_lines();
        logic [7:1] e;
        e = 7'h7f;
        for (int s = 0; s < 4; s++) begin
            if (!src_n[s] && ctl_m[s][4] && ctl_m[s][2:0] != 3'h0) e[ctl_m[s][2:0]] = 1'b0;
        end
        return e;
    endfunction
    // Chip select only while the strobes would frame the access
    task wr(input logic [2:0] a, input logic [7:0] v);
        int n;
        @(negedge clk);
        req.addr = a;
        req.read = 1'b0;
        req.wdata = v;
        req.sel_n = 1'b0;
        n = 0;
        while (rsp.xfer_ack_n !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({6'h0, rsp.xfer_ack_n, rsp.data_oe_n}, 8'h01);
        req.sel_n = 1'b1;
        if (a < 4) ctl_m[a] = v;
        else vec_m[a-4] = v;
        repeat (4) @(negedge clk);
    endtask
    task rd(input logic [2:0] a, output logic [7:0] v);
        int n;
        @(negedge clk);
        req.addr = a;
        req.read = 1'b1;
        req.sel_n = 1'b0;
        n = 0;
        while (rsp.data_oe_n !== 1'b0 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({7'h0, rsp.xfer_ack_n}, 8'h01);
        @(negedge clk);
        check({7'h0, rsp.xfer_ack_n}, 8'h00);
        v = data_line;
        req.sel_n = 1'b1;
        repeat (4) @(negedge clk);
        check({7'h0, rsp.data_oe_n}, 8'h01);
    endtask
    // Acknowledge cycle, qualified as the strobes would qualify it
    task iack(input logic [2:0] l, input logic chain_n);
        @(negedge clk);
        req.addr = l;
        req.read = 1'b1;
        req.chain_in_n = chain_n;
        req.ack_cycle_n = 1'b0;
        repeat (6) @(negedge clk);
        got_oe = rsp.data_oe_n;
        got_d = data_line;
        got_v = idx_v_n;
        got_i = {idx1, idx0};
        got_co = rsp.chain_out_n;
        got_a = rsp.xfer_ack_n;
        req.ack_cycle_n = 1'b1;
        req.chain_in_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        conclude;
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int a = 0; a < 8; a++) begin
            rd(a, d);
            check(d, a < 4 ? CTL_RST : VEC_RST);
        end
        for (int a = 0; a < 8; a++) begin
            d = $random(seed);
            if (a < 4) d = d & 8'hef;
            wr(a, d);
            rd(a, d);
            check(d, a < 4 ? ctl_m[a] : vec_m[a-4]);
        end
        for (int s = 0; s < 4; s++) begin
            lvl = 1 + ($unsigned($random(seed)) % 7);
            src_n[s] = 1'b0;
            wr(s, lvl);
            check({1'b0, irq_line}, 8'h7f);
            wr(s, 8'h10);
            check({1'b0, irq_line}, 8'h7f);
            wr(s, 8'h10 | (s[0] ? 8'h08 : 8'h00) | lvl);
            check({1'b0, irq_line}, {1'b0, exp_lines()});
            iack(lvl, 1'b1);
            check({got_a, got_oe, got_v, got_co}, 8'h0f);
            iack(lvl % 7 + 1, 1'b0);
            check({got_a, got_oe, got_v, got_co}, 8'h0e);
            iack(lvl, 1'b0);
            check({got_oe, got_v, got_co, got_a, 2'h0, got_i}, {6'h08, s[1:0]});
            check(got_d, vec_m[s]);
            if (s[0]) ctl_m[s][4] = 1'b0;
            rd(s, d);
            check(d & 8'h3f, ctl_m[s] & 8'h3f);
            check({1'b0, irq_line}, {1'b0, exp_lines()});
            wr(s, 8'h00);
            src_n[s] = 1'b1;
        end
        wr(0, 8'h32);
        src_n[0] = 1'b0;
        iack(2, 1'b0);
        check({got_oe, got_v, got_co, got_a, 2'h0, got_i}, 8'hb0);
        wr(0, 8'h00);
        src_n = 4'h9;
        wr(1, 8'h13);
        wr(2, 8'h13);
        iack(3, 1'b0);
        check({got_oe, got_v, got_a, 3'h0, got_i}, 8'h01);
        check(got_d, vec_m[1]);
        check({1'b0, irq_line}, {1'b0, exp_lines()});
        conclude;
    end
endmodule
